// File: hdl/fsq_pkg.sv
package fsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // link bytes
  localparam logic [7:0] SYNC1_BYTE = 8'h86;
  localparam logic [7:0] SYNC2_BYTE = 8'h79;
  localparam logic [7:0] CMD_STATUS = 8'hc3;
  localparam logic [7:0] CMD_PRODUCT_ID = 8'hc0;
  localparam logic [7:0] CMD_SEC_SET = 8'hfa;
  localparam logic [7:0] ERR_CMD = 8'ha1;
  localparam logic [7:0] ERR_FRAME = 8'ha3;
  localparam logic [7:0] ERR_OVERRUN = 8'h63;
  localparam logic [7:0] START_MARK = 8'h3a;
  localparam logic [7:0] BYTE_COUNT = 8'h04;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // reply lengths, echo included only in PKT_LEN
  localparam logic [3:0] ECHO_LEN = 4'h1;
  localparam logic [3:0] ERR_LEN = 4'h3;
  localparam logic [3:0] STATUS_LEN = 4'h7;
  localparam logic [3:0] PKT_LEN = 4'h8;
  localparam int BUF_DEPTH = 8;

  ////////////////////////////////////////////////////////////////////////////
  // top flash area
  localparam int TOP_BYTES = 32;
  localparam int TOP_BASE = 'hffe0;
  localparam int ERASE_PW_ADDR = 'hfffa;
  localparam int DEBUG_CHK_ADDR = 'hfffb;
  localparam int ERASE_PW_IDX = ERASE_PW_ADDR - TOP_BASE;
  localparam int DEBUG_CHK_IDX = DEBUG_CHK_ADDR - TOP_BASE;

  ////////////////////////////////////////////////////////////////////////////
  // status code 1 bit positions
  localparam int ST_DEBUG_BIT = 0;
  localparam int ST_ERASE_PW_BIT = 1;
  localparam int ST_SEC_BIT = 2;
  localparam int ST_BLANK_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic valid;
    logic frame_err;
    logic overrun;
    logic [7:0] data;
  } fsq_rx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fsq_tx_t;

  typedef struct packed {
    logic security_program_enabled_flag;
    logic blank;
    logic erase_password_check_flag;
    logic debug_security_check_flag;
  } fsq_flags_t;

  typedef struct packed {
    logic valid;
    logic ok;
  } fsq_pw_t;

  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
  } fsq_exec_t;

  typedef enum logic [1:0] {V_ALLOW, V_PASS, V_DENY, V_UNKNOWN} fsq_verdict_t;

  typedef enum logic [2:0] {S_SYNC1, S_SYNC2, S_CMD, S_SEND, S_PW, S_IDLE} fsq_state_t;

endpackage : fsq_pkg

// File: hdl/fsq_status.sv
`timescale 1ns/1ps
module fsq_status
  import fsq_pkg::*;
#(
  parameter int TOP_N = TOP_BYTES
) (
  // flash contents
  input wire logic [8*TOP_N-1:0] i_top_area,
  input wire logic i_sec_enabled,
  // status
  output fsq_flags_t o_flags,
  output logic [7:0] o_code,
  output logic [7:0] o_csum
);

  always_comb begin
    o_flags = '0;
    o_flags.security_program_enabled_flag = i_sec_enabled;
    for (int k = 0; k < TOP_N; k++) begin
      if (i_top_area[8*k +: 8] != ERASED_BYTE) begin
        o_flags.blank = 1'b1;
      end
    end
    o_flags.erase_password_check_flag = (i_top_area[8*ERASE_PW_IDX +: 8] != ERASED_BYTE);
    o_flags.debug_security_check_flag = (i_top_area[8*DEBUG_CHK_IDX +: 8] != ERASED_BYTE);
    o_code = 8'h00;
    o_code[ST_DEBUG_BIT] = o_flags.debug_security_check_flag;
    o_code[ST_ERASE_PW_BIT] = o_flags.erase_password_check_flag;
    o_code[ST_SEC_BIT] = o_flags.security_program_enabled_flag;
    o_code[ST_BLANK_BIT] = o_flags.blank;
    o_csum = 8'(8'h00 - o_code - RESERVED_BYTE - RESERVED_BYTE - RESERVED_BYTE);
  end

endmodule : fsq_status

// File: hdl/fsq_cmd.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - echo first sync byte, else stay silent
// R2 - echo second sync byte, else stay silent
// R3 - echo accepted status command code
// R4 - rejected command gets error byte three times
// R5 - after triple error, go idle and silent
// R6 - packet: mark, count, code, three zeros
// R7 - status packet is seven bytes long
// R8 - status code top bit always zero
// R9 - status bits six to four undefined
// R10 - checksum negates sum of code and reserved
// R11 - after checksum wait for next command
// R12 - erase password flag from byte fffa
// R13 - debug check flag from byte fffb
// R14 - security flag shows program enabled
// R15 - blank flag set unless top area erased
// R16 - security blocks write and sector erase
// R17 - sum, id, status always allowed
// R18 - password commands run after password ok
// R19 - forbidden command echoed, then go idle
// R20 - status code built fresh per command
// R21 - controller resets after device goes idle
module fsq_cmd
  import fsq_pkg::*;
#(
  parameter logic [7:0] CMD_SUM = 8'h90,
  parameter logic [7:0] CMD_WRITE = 8'h30,
  parameter logic [7:0] CMD_READ = 8'h40,
  parameter logic [7:0] CMD_CHIP_ERASE = 8'hf0,
  parameter logic [7:0] CMD_SECTOR_ERASE = 8'hf1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial byte link
  input wire fsq_rx_t i_rx,
  input wire logic i_tx_ready,
  output fsq_tx_t o_tx,
  // flash state
  input wire logic [8*TOP_BYTES-1:0] i_top_area,
  input wire logic i_sec_enabled,
  // command dispatch
  input wire fsq_pw_t i_pw,
  output fsq_exec_t o_exec,
  output logic o_pw_req,
  output logic o_idle,
  output fsq_flags_t o_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // live status

  fsq_flags_t st_flags;
  logic [7:0] st_code;
  logic [7:0] st_csum;

  fsq_status #(
    .TOP_N(TOP_BYTES)
  ) u_status (
    .i_top_area(i_top_area),
    .i_sec_enabled(i_sec_enabled),
    .o_flags(st_flags),
    .o_code(st_code),
    .o_csum(st_csum)
  ); // [R12] [R13] [R14] [R15] [R20]

  function automatic fsq_verdict_t judge(input logic [7:0] c, input fsq_flags_t f);
    fsq_verdict_t v;
    v = V_UNKNOWN;
    if (c == CMD_STATUS || c == CMD_PRODUCT_ID || c == CMD_SUM) begin
      v = V_ALLOW; // [R17]
    end else if (c == CMD_WRITE || c == CMD_READ) begin
      v = f.security_program_enabled_flag ? V_DENY : (f.blank ? V_PASS : V_ALLOW); // [R16]
    end else if (c == CMD_CHIP_ERASE) begin
      v = (f.blank && f.erase_password_check_flag) ? V_PASS : V_ALLOW; // [R12]
    end else if (c == CMD_SECTOR_ERASE) begin
      v = (!f.security_program_enabled_flag && f.blank && f.erase_password_check_flag) ?
          V_PASS : V_DENY; // [R16]
    end else if (c == CMD_SEC_SET) begin
      v = f.blank ? V_PASS : V_DENY;
    end
    return v;
  endfunction : judge

  ////////////////////////////////////////////////////////////////////////////
  // state

  fsq_state_t state, next_state;
  fsq_state_t after, next_after;
  logic [7:0] tx_buf [BUF_DEPTH];
  logic [7:0] next_tx_buf [BUF_DEPTH];
  logic [3:0] buf_len, next_buf_len;
  logic [2:0] buf_idx, next_buf_idx;
  logic exec_after, next_exec_after;
  logic [7:0] pend_cmd, next_pend_cmd;
  fsq_tx_t next_o_tx;
  fsq_exec_t next_o_exec;
  logic next_o_pw_req;
  logic next_o_idle;
  fsq_flags_t next_o_flags;

  always_comb begin
    fsq_verdict_t v;
    logic ld;
    v = judge(i_rx.data, st_flags);
    ld = 1'b0;
    next_state = state;
    next_after = after;
    next_tx_buf = tx_buf;
    next_buf_len = buf_len;
    next_buf_idx = buf_idx;
    next_exec_after = exec_after;
    next_pend_cmd = pend_cmd;
    next_o_tx = o_tx;
    next_o_exec = '0;
    next_o_pw_req = o_pw_req;
    next_o_idle = o_idle;
    next_o_flags = o_flags;
    case (state)
      S_SYNC1: begin
        if (i_rx.valid && !i_rx.frame_err && !i_rx.overrun && i_rx.data == SYNC1_BYTE) begin
          ld = 1'b1; // [R1]
          next_tx_buf[0] = SYNC1_BYTE;
          next_buf_len = ECHO_LEN;
          next_after = S_SYNC2;
        end
      end
      S_SYNC2: begin
        if (i_rx.valid && !i_rx.frame_err && !i_rx.overrun && i_rx.data == SYNC2_BYTE) begin
          ld = 1'b1; // [R2]
          next_tx_buf[0] = SYNC2_BYTE;
          next_buf_len = ECHO_LEN;
          next_after = S_CMD;
        end
      end
      S_CMD: begin
        if (i_rx.valid) begin
          ld = 1'b1;
          next_exec_after = 1'b0;
          next_pend_cmd = i_rx.data;
          next_tx_buf[0] = i_rx.data; // [R3]
          next_buf_len = ECHO_LEN;
          next_after = S_CMD;
          if (i_rx.frame_err || i_rx.overrun || v == V_UNKNOWN) begin
            for (int k = 0; k < 3; k++) begin
              next_tx_buf[k] = i_rx.frame_err ? ERR_FRAME :
                               (i_rx.overrun ? ERR_OVERRUN : ERR_CMD); // [R4]
            end
            next_buf_len = ERR_LEN;
            next_after = S_IDLE; // [R5]
          end else if (i_rx.data == CMD_STATUS) begin
            next_tx_buf[1] = START_MARK; // [R6]
            next_tx_buf[2] = BYTE_COUNT;
            next_tx_buf[3] = st_code; // [R8] [R9] [R20]
            next_tx_buf[4] = RESERVED_BYTE;
            next_tx_buf[5] = RESERVED_BYTE;
            next_tx_buf[6] = RESERVED_BYTE;
            next_tx_buf[7] = st_csum; // [R10]
            next_buf_len = ECHO_LEN + STATUS_LEN; // [R7]
            next_o_flags = st_flags; // [R14]
          end else if (v == V_ALLOW) begin
            next_exec_after = 1'b1; // [R17]
          end else if (v == V_PASS) begin
            next_after = S_PW; // [R18]
          end else begin
            next_after = S_IDLE; // [R19]
          end
        end
      end
      S_SEND: begin
        if (o_tx.valid && i_tx_ready) begin
          if (4'({1'b0, buf_idx}) + 4'h1 == buf_len) begin
            next_o_tx = '0;
            next_state = after; // [R11]
            next_o_pw_req = (after == S_PW);
            next_o_idle = (after == S_IDLE); // [R5] [R19]
            if (exec_after) begin
              next_o_exec = '{valid: 1'b1, cmd: pend_cmd};
            end
          end else begin
            next_buf_idx = 3'(buf_idx + 3'h1);
            next_o_tx.data = tx_buf[3'(buf_idx + 3'h1)];
          end
        end
      end
      S_PW: begin
        if (i_pw.valid) begin
          next_o_pw_req = 1'b0;
          if (i_pw.ok) begin
            next_o_exec = '{valid: 1'b1, cmd: pend_cmd}; // [R18]
            next_state = S_CMD;
          end else begin
            next_state = S_IDLE;
            next_o_idle = 1'b1;
          end
        end
      end
      S_IDLE: begin
        next_state = S_IDLE; // [R5]
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (ld) begin
      next_state = S_SEND;
      next_buf_idx = 3'h0;
      next_o_tx = '{valid: 1'b1, data: next_tx_buf[0]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= S_SYNC1;
      after <= S_SYNC1;
      for (int k = 0; k < BUF_DEPTH; k++) begin
        tx_buf[k] <= 8'h00;
      end
      buf_len <= 4'h0;
      buf_idx <= 3'h0;
      exec_after <= 1'b0;
      pend_cmd <= 8'h00;
      o_tx <= '0;
      o_exec <= '0;
      o_pw_req <= 1'b0;
      o_idle <= 1'b0;
      o_flags <= '0;
    end else begin
      state <= next_state;
      after <= next_after;
      tx_buf <= next_tx_buf;
      buf_len <= next_buf_len;
      buf_idx <= next_buf_idx;
      exec_after <= next_exec_after;
      pend_cmd <= next_pend_cmd;
      o_tx <= next_o_tx;
      o_exec <= next_o_exec;
      o_pw_req <= next_o_pw_req;
      o_idle <= next_o_idle;
      o_flags <= next_o_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic rx_clean;
  assign rx_clean = i_rx.valid && !i_rx.frame_err && !i_rx.overrun;

  sequence s_sync1_hit;
    state == S_SYNC1 && rx_clean && i_rx.data == SYNC1_BYTE;
  endsequence

  sequence s_status_hit;
    state == S_CMD && rx_clean && i_rx.data == CMD_STATUS;
  endsequence

  property p_sync1_echo;
    s_sync1_hit |=> o_tx.valid && o_tx.data == SYNC1_BYTE && buf_len == ECHO_LEN;
  endproperty
  a_sync1_echo: assert property (p_sync1_echo) else $error("sync1 not echoed"); // [R1]

  property p_sync1_silent;
    state == S_SYNC1 && i_rx.valid && i_rx.data != SYNC1_BYTE |=> !o_tx.valid;
  endproperty
  a_sync1_silent: assert property (p_sync1_silent) else $error("bad sync1 answered"); // [R1]

  property p_sync2_echo;
    state == S_SYNC2 && rx_clean && i_rx.data == SYNC2_BYTE
      |=> o_tx.valid && o_tx.data == SYNC2_BYTE ##0 after == S_CMD;
  endproperty
  a_sync2_echo: assert property (p_sync2_echo) else $error("sync2 not echoed"); // [R2]

  property p_status_echo;
    s_status_hit |=> o_tx.valid && o_tx.data == CMD_STATUS;
  endproperty
  a_status_echo: assert property (p_status_echo) else $error("status code not echoed"); // [R3]

  property p_err_triple;
    state == S_CMD && i_rx.valid && i_rx.frame_err
      |=> buf_len == ERR_LEN && o_tx.data == ERR_FRAME && tx_buf[2] == ERR_FRAME
          && after == S_IDLE;
  endproperty
  a_err_triple: assert property (p_err_triple) else $error("error triple wrong"); // [R4]

  property p_idle_silent;
    state == S_IDLE |-> !o_tx.valid && o_idle && !o_exec.valid;
  endproperty
  a_idle_silent: assert property (p_idle_silent) else $error("idle device talks"); // [R5]

  property p_packet;
    s_status_hit |=> buf_len == PKT_LEN && tx_buf[1] == START_MARK
      && tx_buf[2] == BYTE_COUNT && tx_buf[4] == 8'h00 && tx_buf[5] == 8'h00
      && tx_buf[6] == 8'h00 && after == S_CMD;
  endproperty
  a_packet: assert property (p_packet) else $error("status packet malformed"); // [R6]

  property p_code_range;
    st_code[7:4] == 4'h0;
  endproperty
  a_code_range: assert property (p_code_range) else $error("status code out of range"); // [R8]

  property p_checksum;
    s_status_hit |=> 8'(tx_buf[3] + tx_buf[4] + tx_buf[5] + tx_buf[6] + tx_buf[7]) == 8'h00;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum wrong"); // [R10]

  property p_sec_block;
    o_exec.valid && i_sec_enabled |-> o_exec.cmd != CMD_WRITE
      && o_exec.cmd != CMD_SECTOR_ERASE;
  endproperty
  a_sec_block: assert property (p_sec_block) else $error("secured command ran"); // [R16]

  property p_pw_gate;
    state == S_PW ##1 o_exec.valid |-> $past(i_pw.valid && i_pw.ok);
  endproperty
  a_pw_gate: assert property (p_pw_gate) else $error("run without password"); // [R18]

endmodule : fsq_cmd

// File: sim/fsq_ctrl_model.sv
`timescale 1ns/1ps
module fsq_ctrl_model
  import fsq_pkg::*;
(
  // clock and pacing
  input wire logic i_clk,
  input wire logic i_slow,
  // device reply side
  input wire fsq_tx_t i_tx,
  // controller outputs
  output fsq_rx_t o_rx,
  output logic o_tx_ready
);
  logic [7:0] got[$];
  logic [1:0] cnt = 2'h0;

  initial begin
    o_rx = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply acceptance, one in four cycles when slow
  always @(negedge i_clk) begin
    cnt <= cnt + 2'h1;
    o_tx_ready <= !i_slow || (cnt == 2'h3);
  end

  always @(posedge i_clk) begin
    if (i_tx.valid === 1'b1 && o_tx_ready) begin
      got.push_back(i_tx.data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one byte, then line data shows inverse
  task automatic send(input logic [7:0] b, input logic fe, input logic ov);
    @(negedge i_clk);
    o_rx = '{valid: 1'b1, frame_err: fe, overrun: ov, data: b};
    @(negedge i_clk);
    o_rx = '{valid: 1'b0, frame_err: 1'b0, overrun: 1'b0, data: ~b};
  endtask : send
endmodule : fsq_ctrl_model

// File: sim/fsq_cmd_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fsq_cmd_tb_top;
  import fsq_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_slow = 1'b0;
  logic [8*TOP_BYTES-1:0] i_top_area = '1;
  logic i_sec_enabled = 1'b0;
  fsq_pw_t i_pw = '0;
  fsq_rx_t rx;
  fsq_tx_t tx;
  logic tx_ready;
  fsq_exec_t exec;
  logic pw_req;
  logic idle;
  fsq_flags_t flags;
  int num_errors = 0;
  int checked = 0;
  int exec_cnt = 0;
  int n0;
  logic [7:0] exec_cmd = 8'h00;
  logic [7:0] code;
  logic [7:0] cmd;
  logic [7:0] e;
  logic sec, bl, ep;
  logic [1:0] kind;
  // sec, blank, erase pw, command, 0 allow 1 password 2 deny
  localparam logic [12:0] PERM[12] = '{
    {3'b000, 8'h30, 2'h0}, {3'b100, 8'h30, 2'h2}, {3'b100, 8'hf0, 2'h0},
    {3'b010, 8'h30, 2'h1}, {3'b011, 8'hf1, 2'h1}, {3'b110, 8'hf1, 2'h2},
    {3'b111, 8'hf0, 2'h1}, {3'b110, 8'h90, 2'h0}, {3'b000, 8'hfa, 2'h2},
    {3'b110, 8'hc0, 2'h0}, {3'b010, 8'h40, 2'h1}, {3'b010, 8'hfa, 2'h1}};

  always #50 i_clk = ~i_clk;

  fsq_cmd u_fsq_cmd (.i_clk(i_clk), .i_rst(i_rst), .i_rx(rx), .i_tx_ready(tx_ready),
    .o_tx(tx), .i_top_area(i_top_area), .i_sec_enabled(i_sec_enabled), .i_pw(i_pw),
    .o_exec(exec), .o_pw_req(pw_req), .o_idle(idle), .o_flags(flags));

  fsq_ctrl_model u_fsq_ctrl_model (.i_clk(i_clk), .i_slow(i_slow), .i_tx(tx),
    .o_rx(rx), .o_tx_ready(tx_ready));

  always @(posedge i_clk) begin
    if (exec.valid === 1'b1) begin
      exec_cnt <= exec_cnt + 1;
      exec_cmd <= exec.cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic results();
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic xfer(input logic [7:0] b, input logic fe, input logic ov, input int n);
    int k;
    k = 0;
    u_fsq_ctrl_model.got.delete();
    u_fsq_ctrl_model.send(b, fe, ov);
    while (u_fsq_ctrl_model.got.size() < n && k < 300) begin
      @(negedge i_clk);
      k++;
    end
    repeat (4) @(negedge i_clk);
  endtask : xfer

  task automatic expect_bytes(input logic [7:0] exp[$]);
    `CHK(u_fsq_ctrl_model.got.size(), exp.size())
    foreach (exp[k]) begin
      if (k < u_fsq_ctrl_model.got.size()) `CHK(u_fsq_ctrl_model.got[k], exp[k])
    end
  endtask : expect_bytes

  task automatic restart();
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    xfer(SYNC1_BYTE, 1'b0, 1'b0, 1);
    expect_bytes('{SYNC1_BYTE});
    xfer(SYNC2_BYTE, 1'b0, 1'b0, 1);
    expect_bytes('{SYNC2_BYTE});
  endtask : restart

  function automatic logic [255:0] mk_area(input logic b, input logic p, input logic d);
    logic [255:0] a;
    a = '1;
    if (b) a[7:0] = 8'h5a;
    if (p) a[8*26+:8] = 8'h00;
    if (d) a[8*27+:8] = 8'h20;
    return a;
  endfunction : mk_area

  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    xfer(8'h55, 1'b0, 1'b0, 1);
    `CHK(u_fsq_ctrl_model.got.size(), 0)
    xfer(SYNC1_BYTE, 1'b1, 1'b0, 1);
    `CHK(u_fsq_ctrl_model.got.size(), 0)
    xfer(SYNC1_BYTE, 1'b0, 1'b0, 1);
    expect_bytes('{SYNC1_BYTE});
    xfer(SYNC2_BYTE, 1'b0, 1'b1, 1);
    `CHK(u_fsq_ctrl_model.got.size(), 0)
    xfer(SYNC2_BYTE, 1'b0, 1'b0, 1);
    expect_bytes('{SYNC2_BYTE});
    for (int c = 0; c < 3; c++) begin
      i_slow = (c == 1);
      i_sec_enabled = (c == 2);
      i_top_area = mk_area(c > 0, c == 1, c == 2);
      code = {4'h0, c > 0, c == 2, c == 1, c == 2};
      xfer(CMD_STATUS, 1'b0, 1'b0, 8);
      expect_bytes('{CMD_STATUS, START_MARK, BYTE_COUNT, code, 8'h00, 8'h00, 8'h00,
        8'h00 - code});
      `CHK(u_fsq_ctrl_model.got[3][7:4], 4'h0)
      `CHK(flags, {code[2], code[3], code[1], code[0]})
    end
    i_slow = 1'b0;
    for (int p = 0; p < 12; p++) begin
      {sec, bl, ep, cmd, kind} = PERM[p];
      restart();
      i_sec_enabled = sec;
      i_top_area = mk_area(bl, ep, 1'b0);
      n0 = exec_cnt;
      xfer(cmd, 1'b0, 1'b0, 1);
      expect_bytes('{cmd});
      if (kind == 2'h1) begin
        `CHK(pw_req, 1'b1)
        i_pw = '{valid: 1'b1, ok: 1'b1};
        @(negedge i_clk);
        i_pw = '0;
        repeat (3) @(negedge i_clk);
      end
      `CHK(exec_cnt, n0 + int'(kind != 2'h2))
      if (kind != 2'h2) `CHK(exec_cmd, cmd)
      `CHK(idle, kind == 2'h2)
    end
    // failed password stops device
    restart();
    i_sec_enabled = 1'b0;
    i_top_area = mk_area(1'b1, 1'b0, 1'b0);
    n0 = exec_cnt;
    xfer(8'h30, 1'b0, 1'b0, 1);
    expect_bytes('{8'h30});
    `CHK(pw_req, 1'b1)
    i_pw = '{valid: 1'b1, ok: 1'b0};
    @(negedge i_clk);
    i_pw = '0;
    repeat (3) @(negedge i_clk);
    `CHK(exec_cnt, n0)
    `CHK(pw_req, 1'b0)
    `CHK(idle, 1'b1)
    for (int i = 0; i < 3; i++) begin
      restart();
      e = (i == 0) ? ERR_FRAME : (i == 1) ? ERR_OVERRUN : ERR_CMD;
      xfer((i == 2) ? 8'h77 : CMD_STATUS, i == 0, i == 1, 3);
      expect_bytes('{e, e, e});
      `CHK(idle, 1'b1)
      xfer(CMD_STATUS, 1'b0, 1'b0, 1);
      `CHK(u_fsq_ctrl_model.got.size(), 0)
    end
    results();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    results();
  end
endmodule : fsq_cmd_tb_top
